// ### verilog/timer_pkg.sv
package timer_pkg;

    localparam int NUM_CH = 3;
    localparam int NUM_PINS = 9;

    // Register select codes
    localparam logic [1:0] ADDR_CTRL = 2'h3;

    // Control word field positions
    localparam int SEL_MSB = 7;
    localparam int SEL_LSB = 6;
    localparam int FMT_MSB = 5;
    localparam int FMT_LSB = 4;
    localparam int MODE_MSB = 3;
    localparam int MODE_LSB = 1;
    localparam int BCD_BIT = 0;

    localparam logic [1:0] SEL_ILLEGAL = 2'h3;
    localparam logic [1:0] FMT_LATCH = 2'h0;
    localparam logic [1:0] FMT_LOW = 2'h1;
    localparam logic [1:0] FMT_HIGH = 2'h2;
    localparam logic [1:0] FMT_WORD = 2'h3;

    // Waveform mode codes after folding the don't-care top bit
    localparam logic [2:0] MODE_TC = 3'h0;
    localparam logic [2:0] MODE_ONE = 3'h1;
    localparam logic [2:0] MODE_RATE = 3'h2;
    localparam logic [2:0] MODE_SQ = 3'h3;
    localparam logic [2:0] MODE_SW = 3'h4;
    localparam logic [2:0] MODE_HW = 3'h5;

    // Synchronised pin slots
    localparam int PIN_CLK0 = 0;
    localparam int PIN_GATE0 = 3;
    localparam int PIN_CS = 6;
    localparam int PIN_RD = 7;
    localparam int PIN_WR = 8;
    localparam logic [NUM_PINS-1:0] PIN_INIT = 9'h1c0;

    localparam logic [15:0] COUNT_ONE = 16'h0001;
    localparam logic [15:0] COUNT_TWO = 16'h0002;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;

    typedef struct packed {
        logic       cs_b;
        logic       rd_b;
        logic       wr_b;
        logic [1:0] addr;
        logic [7:0] data;
    } host_bus_t;

    typedef struct packed {
        logic [2:0]  mode;
        logic        bcd;
        logic [1:0]  fmt;
        logic [15:0] count;
        logic [15:0] reload;
        logic [15:0] hold;
        logic        latched;
        logic        rd_hi;
        logic        wr_hi;
        logic        armed;
        logic        running;
        logic        load_pend;
        logic        trig;
        logic        extra;
        logic        out;
    } chan_t;

    typedef struct packed {
        chan_t [NUM_CH-1:0]    ch;
        logic [NUM_PINS-1:0]   pins_prev;
        logic [7:0]            rd_data;
        logic                  rd_oe;
    } timer_state_t;

    localparam timer_state_t TIMER_RESET = '{
        ch: '0,
        pins_prev: PIN_INIT,
        rd_data: 8'h00,
        rd_oe: 1'b0
    };

endpackage

// ### verilog/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT  = '0
) (
    input  logic             clk,
    input  logic             rst_b,
    input  logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
    } sync_t;

    sync_t st;
    sync_t next_st;

    // Level moves only once stages two and three agree
    always_comb begin
        next_st = st;
        next_st.s1 = pin;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.lvl[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st <= {INIT, INIT, INIT, INIT};
        end else begin
            st <= next_st;
        end
    end

    assign level = st.lvl;
endmodule

// ### verilog/count_step.sv
`timescale 1ns/1ps
module count_step (
    input  logic [15:0] value,
    input  logic        bcd,
    input  logic        two,
    output logic [15:0] result
);
    // Down step of one or two, per decade when decimal
    always_comb begin
        logic [4:0] amt;
        logic [4:0] dig;
        amt = two ? 5'h02 : 5'h01;
        dig = 5'h00;
        result = 16'h0000;
        if (bcd) begin
            for (int d = 0; d < 4; d++) begin
                dig = {1'b0, value[4*d +: 4]};
                if (dig >= amt) begin
                    result[4*d +: 4] = 4'(dig - amt);
                    amt = 5'h00;
                end else begin
                    result[4*d +: 4] = 4'(dig + 5'h0a - amt);
                    amt = 5'h01;
                end
            end
        end else begin
            result = 16'(value - {11'h000, amt});
        end
    end
endmodule

// ### verilog/interval_timer.sv
`timescale 1ns/1ps
module interval_timer
    import timer_pkg::*;
(
    input  logic      clk,
    input  logic      rst_b,
    input  host_bus_t host_bus_in,
    input  logic [2:0] count_enable_inputs,
    input  logic [2:0] counter_clock_pins,
    output logic [7:0] data_out,
    output logic      data_oe,
    output logic [2:0] counter_waveform_pins
);
    timer_state_t st;
    timer_state_t next_st;

    logic [NUM_PINS-1:0] pins_f;
    logic [15:0]         dec [NUM_CH];

    // Every strobe, select, enable and clock pin goes through the same filter
    pin_sync #(
        .WIDTH (NUM_PINS),
        .INIT  (PIN_INIT)
    ) u_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .pin   ({host_bus_in.wr_b, host_bus_in.rd_b, host_bus_in.cs_b,
                 count_enable_inputs, counter_clock_pins}),
        .level (pins_f)
    );

    // One down-stepper per counter
    for (genvar g = 0; g < NUM_CH; g++) begin : g_step
        count_step u_step (
            .value  (st.ch[g].count),
            .bcd    (st.ch[g].bcd),
            .two    (st.ch[g].mode == MODE_SQ),
            .result (dec[g])
        );
    end

    // Completed count load: what starts depends on the mode
    function automatic chan_t load_done(input chan_t c);
        chan_t r;
        r = c;
        r.armed = 1'b1;
        case (c.mode)
            MODE_TC: begin
                r.out = 1'b0;
                r.load_pend = 1'b1;
                r.running = 1'b0;
            end
            MODE_SW: begin
                r.load_pend = 1'b1;
                r.running = 1'b0;
            end
            MODE_RATE, MODE_SQ: begin
                // Running counters pick up the new value at reload
                if (!c.running) begin
                    r.load_pend = 1'b1;
                end
            end
            default: begin
                // One-shot modes wait for an enable edge
                r.load_pend = 1'b0;
            end
        endcase
        return r;
    endfunction

    // Host bus events and counter stepping
    always_comb begin
        logic        tick;
        logic        gate;
        logic        grise;
        logic        wr_end;
        logic        rd_end;
        logic [1:0]  a;
        logic [1:0]  sel;
        logic [2:0]  m;
        logic [7:0]  d;
        logic [15:0] src;
        logic        old_out;
        tick = 1'b0;
        gate = 1'b0;
        grise = 1'b0;
        a = host_bus_in.addr;
        d = host_bus_in.data;
        sel = d[SEL_MSB:SEL_LSB];
        m = d[MODE_MSB:MODE_LSB];
        src = COUNT_ZERO;
        old_out = 1'b0;
        next_st = st;
        next_st.pins_prev = pins_f;
        // Strobe ends only count while chip select is low
        wr_end = !st.pins_prev[PIN_WR] && pins_f[PIN_WR] && !pins_f[PIN_CS];
        rd_end = !st.pins_prev[PIN_RD] && pins_f[PIN_RD] && !pins_f[PIN_CS];

        for (int i = 0; i < NUM_CH; i++) begin
            // Counting happens on the falling edge of the counter clock
            tick = st.pins_prev[PIN_CLK0+i] && !pins_f[PIN_CLK0+i];
            gate = pins_f[PIN_GATE0+i];
            grise = gate && !st.pins_prev[PIN_GATE0+i];
            old_out = st.ch[i].out;

            // Edge is held until the next counter clock consumes it
            if (grise) begin
                next_st.ch[i].trig = 1'b1;
            end
            if (grise && st.ch[i].armed &&
                (st.ch[i].mode == MODE_RATE || st.ch[i].mode == MODE_SQ ||
                 st.ch[i].mode == MODE_SW)) begin
                next_st.ch[i].load_pend = 1'b1;
            end

            // Enable low holds modes 2 and 3 high at once
            if ((st.ch[i].mode == MODE_RATE || st.ch[i].mode == MODE_SQ) && !gate) begin
                next_st.ch[i].out = 1'b1;
                next_st.ch[i].running = 1'b0;
                next_st.ch[i].extra = 1'b0;
            end

            if (tick) begin
                case (st.ch[i].mode)
                    MODE_TC, MODE_SW: begin
                        if (st.ch[i].mode == MODE_SW && !old_out) begin
                            next_st.ch[i].out = 1'b1;
                        end
                        if (st.ch[i].load_pend) begin
                            next_st.ch[i].count = st.ch[i].reload;
                            next_st.ch[i].load_pend = 1'b0;
                            next_st.ch[i].running = 1'b1;
                        end else if (st.ch[i].running && gate) begin
                            next_st.ch[i].count = dec[i];
                            // Zero only after a decrement from one
                            if (dec[i] == COUNT_ZERO) begin
                                if (st.ch[i].mode == MODE_TC) begin
                                    next_st.ch[i].out = 1'b1;
                                end else begin
                                    next_st.ch[i].out = 1'b0;
                                    next_st.ch[i].running = 1'b0;
                                end
                            end
                        end
                    end
                    MODE_ONE, MODE_HW: begin
                        if (st.ch[i].mode == MODE_HW && !old_out) begin
                            next_st.ch[i].out = 1'b1;
                        end
                        if (st.ch[i].trig) begin
                            // Trigger loads the latest count and retriggers
                            next_st.ch[i].trig = grise;
                            next_st.ch[i].count = st.ch[i].reload;
                            next_st.ch[i].running = st.ch[i].armed;
                            if (st.ch[i].mode == MODE_ONE && st.ch[i].armed) begin
                                next_st.ch[i].out = 1'b0;
                            end
                        end else if (st.ch[i].running) begin
                            // Enable level is ignored once running
                            next_st.ch[i].count = dec[i];
                            if (dec[i] == COUNT_ZERO) begin
                                next_st.ch[i].running = 1'b0;
                                next_st.ch[i].out = (st.ch[i].mode == MODE_ONE);
                            end
                        end
                    end
                    MODE_RATE: begin
                        if (!gate) begin
                            next_st.ch[i].out = 1'b1;
                        end else if (st.ch[i].load_pend) begin
                            next_st.ch[i].count = st.ch[i].reload;
                            next_st.ch[i].load_pend = 1'b0;
                            next_st.ch[i].running = 1'b1;
                            next_st.ch[i].out = 1'b1;
                        end else if (st.ch[i].running) begin
                            if (st.ch[i].count == COUNT_ONE) begin
                                // New count takes over after the pulse
                                next_st.ch[i].count = st.ch[i].reload;
                                next_st.ch[i].out = 1'b1;
                            end else begin
                                next_st.ch[i].count = dec[i];
                                next_st.ch[i].out = (dec[i] != COUNT_ONE);
                            end
                        end
                    end
                    MODE_SQ: begin
                        // Odd counts spend one extra clock in the high half
                        if (!gate) begin
                            next_st.ch[i].out = 1'b1;
                        end else if (st.ch[i].load_pend) begin
                            next_st.ch[i].count = {st.ch[i].reload[15:1], 1'b0};
                            next_st.ch[i].extra = st.ch[i].reload[0];
                            next_st.ch[i].load_pend = 1'b0;
                            next_st.ch[i].running = 1'b1;
                            next_st.ch[i].out = 1'b1;
                        end else if (st.ch[i].running) begin
                            if (st.ch[i].extra) begin
                                next_st.ch[i].extra = 1'b0;
                            end else if (st.ch[i].count == COUNT_TWO) begin
                                // Reload at each edge so a rewrite lands here
                                next_st.ch[i].out = !old_out;
                                next_st.ch[i].count = {st.ch[i].reload[15:1], 1'b0};
                                next_st.ch[i].extra = !old_out && st.ch[i].reload[0];
                            end else begin
                                next_st.ch[i].count = dec[i];
                            end
                        end
                    end
                    default: begin
                        next_st.ch[i].running = 1'b0;
                    end
                endcase
            end
        end

        // Host write: control word or count byte
        if (wr_end) begin
            if (a == ADDR_CTRL) begin
                if (sel != SEL_ILLEGAL) begin
                    if (d[FMT_MSB:FMT_LSB] == FMT_LATCH) begin
                        // A second latch before readout is ignored
                        if (!st.ch[sel].latched) begin
                            next_st.ch[sel].hold = next_st.ch[sel].count;
                            next_st.ch[sel].latched = 1'b1;
                        end
                    end else begin
                        if (m[1]) begin
                            m[2] = 1'b0;
                        end
                        next_st.ch[sel] = '0;
                        next_st.ch[sel].mode = m;
                        next_st.ch[sel].bcd = d[BCD_BIT];
                        next_st.ch[sel].fmt = d[FMT_MSB:FMT_LSB];
                        next_st.ch[sel].out = (m != MODE_TC);
                    end
                end
            end else begin
                case (st.ch[a].fmt)
                    FMT_LOW: begin
                        next_st.ch[a].reload = {8'h00, d};
                        next_st.ch[a] = load_done(next_st.ch[a]);
                    end
                    FMT_HIGH: begin
                        next_st.ch[a].reload = {d, 8'h00};
                        next_st.ch[a] = load_done(next_st.ch[a]);
                    end
                    FMT_WORD: begin
                        if (!st.ch[a].wr_hi) begin
                            next_st.ch[a].reload[7:0] = d;
                            next_st.ch[a].wr_hi = 1'b1;
                            if (st.ch[a].mode == MODE_TC) begin
                                next_st.ch[a].running = 1'b0;
                                next_st.ch[a].load_pend = 1'b0;
                            end
                        end else begin
                            next_st.ch[a].reload[15:8] = d;
                            next_st.ch[a].wr_hi = 1'b0;
                            next_st.ch[a] = load_done(next_st.ch[a]);
                        end
                    end
                    default: begin
                        // Unprogrammed counter drops count bytes
                        next_st.ch[a].wr_hi = 1'b0;
                    end
                endcase
            end
        end

        // Read completion moves the byte pointer and frees the latch
        if (rd_end && a != ADDR_CTRL) begin
            if (st.ch[a].fmt == FMT_WORD) begin
                next_st.ch[a].rd_hi = !st.ch[a].rd_hi;
            end
            if (st.ch[a].latched && (st.ch[a].fmt != FMT_WORD || st.ch[a].rd_hi)) begin
                next_st.ch[a].latched = 1'b0;
            end
        end

        // Read data drive, registered so the pins come from flops
        next_st.rd_oe = !pins_f[PIN_CS] && !pins_f[PIN_RD] && a != ADDR_CTRL;
        next_st.rd_data = 8'h00;
        if (a != ADDR_CTRL) begin
            src = st.ch[a].latched ? st.ch[a].hold : st.ch[a].count;
            if (st.ch[a].fmt == FMT_HIGH ||
                (st.ch[a].fmt == FMT_WORD && st.ch[a].rd_hi)) begin
                next_st.rd_data = src[15:8];
            end else begin
                next_st.rd_data = src[7:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st <= TIMER_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from state flops
    assign data_out = st.rd_data;
    assign data_oe = st.rd_oe;
    for (genvar o = 0; o < NUM_CH; o++) begin : g_out
        assign counter_waveform_pins[o] = st.ch[o].out;
    end
endmodule

// ### tb/timer_assertions.sv
`timescale 1ns/1ps
module timer_assertions
    import timer_pkg::*;
(
    input logic       clk,
    input logic       rst_b,
    input host_bus_t  host_bus_in,
    input logic [2:0] count_enable_inputs,
    input logic [2:0] counter_clock_pins,
    input logic [7:0] data_out,
    input logic       data_oe,
    input logic [2:0] counter_waveform_pins
);
    // One domain, so one clock for every check and one reset for all but rst_out_a
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic       cw;
    logic [7:0] d;
    // Control word access; latch commands leave the mode alone
    assign cw = !host_bus_in.cs_b && host_bus_in.addr == ADDR_CTRL;
    assign d  = host_bus_in.data;

    oe_cs_a: assert property (
        $rose(data_oe) |-> !host_bus_in.cs_b && !host_bus_in.rd_b) else $error("bus driven unselected");
    oe_addr_a: assert property (
        data_oe |-> host_bus_in.addr != ADDR_CTRL) else $error("control word read back");
    oe_late_a: assert property (
        $fell(host_bus_in.rd_b) |-> !data_oe [*3]) else $error("bus driven too early");
    oe_rise_a: assert property (
        $fell(host_bus_in.rd_b) && !host_bus_in.cs_b && host_bus_in.addr != ADDR_CTRL
        |-> ##[3:7] data_oe) else $error("read never answered");
    oe_float_a: assert property (
        $rose(host_bus_in.rd_b) |-> ##[1:6] !data_oe) else $error("bus not released");
    cw_low_a: assert property (
        $rose(host_bus_in.wr_b) && cw && d[7:6] == 2'h0 && d[5:4] != FMT_LATCH && d[3:1] == MODE_TC
        |-> ##[3:6] !counter_waveform_pins[0]) else $error("mode 0 output not low");
    cw_high_a: assert property (
        $rose(host_bus_in.wr_b) && cw && d[7:6] == 2'h2 && d[5:4] != FMT_LATCH && d[3:1] != MODE_TC
        |-> ##[3:6] counter_waveform_pins[2]) else $error("output not high at mode set");
    rst_out_a: assert property (disable iff (1'b0)
        !rst_b |=> !data_oe && counter_waveform_pins == 3'h0) else $error("outputs live in reset");

    cover property ($rose(data_oe));
    cover property ($rose(counter_waveform_pins[0]));
    cover property ($fell(counter_waveform_pins[1]));
endmodule

bind interval_timer timer_assertions chk (.clk(clk), .rst_b(rst_b), .host_bus_in(host_bus_in),
    .count_enable_inputs(count_enable_inputs), .counter_clock_pins(counter_clock_pins),
    .data_out(data_out), .data_oe(data_oe), .counter_waveform_pins(counter_waveform_pins));

// ### tb/host_model.sv
`timescale 1ns/1ps
module host_model
    import timer_pkg::*;
(
    input  logic       clk,
    input  logic [7:0] data_out,
    input  logic       data_oe,
    output host_bus_t  bus
);
    // Idle: deselected, both strobes high
    initial bus = '{cs_b: 1'b1, rd_b: 1'b1, wr_b: 1'b1, addr: 2'h0, data: 8'h5a};

    // Write; address and data held 600 ns past the strobe release
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(negedge clk);
        bus.cs_b = 1'b0;
        bus.addr = a;
        bus.data = v;
        bus.wr_b = 1'b0;
        repeat (6) @(negedge clk);
        bus.wr_b = 1'b1;
        repeat (6) @(negedge clk);
        bus.cs_b = 1'b1;
        bus.data = ~v; // Released bus must not keep the byte
    endtask

    // Read; byte taken while the strobe is still low
    task automatic rd(input logic [1:0] a, output logic [7:0] v, output logic oe);
        @(negedge clk);
        bus.cs_b = 1'b0;
        bus.addr = a;
        bus.rd_b = 1'b0;
        repeat (9) @(negedge clk);
        v = data_out;
        oe = data_oe;
        bus.rd_b = 1'b1;
        repeat (7) @(negedge clk);
        bus.cs_b = 1'b1;
    endtask

    // Two-byte load, low then high back to back
    task automatic wr16(input logic [1:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a, v[15:8]);
    endtask

    task automatic rd16(input logic [1:0] a, output logic [15:0] v);
        logic oe;
        rd(a, v[7:0], oe);
        rd(a, v[15:8], oe);
    endtask
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
    import timer_pkg::*;
    logic        clk;
    logic        rst_b;
    logic        cclk;
    logic [2:0]  gate;
    logic [7:0]  data_out;
    logic        data_oe;
    logic [2:0]  wave;
    logic [15:0] v;
    logic [15:0] w;
    logic [7:0]  b;
    logic        oe;
    host_bus_t   bus;
    int          k;
    int          num_errors = 0;
    int          num_checks = 0;
    int          cycles = 0;
    // Rows: mode field for counter 2, then the pin level it should give
    logic [3:0]  rows [8] = '{4'h0, 4'h3, 4'h5, 4'h7, 4'h9, 4'hb, 4'hd, 4'hf};

    interval_timer DUT (.clk(clk), .rst_b(rst_b), .host_bus_in(bus),
        .count_enable_inputs(gate), .counter_clock_pins({3{cclk}}), .data_out(data_out),
        .data_oe(data_oe), .counter_waveform_pins(wave));
    host_model host (.clk(clk), .data_out(data_out), .data_oe(data_oe), .bus(bus));

    // 10 MHz system clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Counter clock at 1 us, moved on falling clk edges like every other input
    initial begin
        cclk = 1'b0;
        forever begin
            repeat (5) @(negedge clk);
            cclk = ~cclk;
        end
    end
    // Hang guard, far above the few thousand cycles the run needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            num_errors = num_errors + 1;
            report_and_stop();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n * 10) @(negedge clk);
    endtask
    // Clock cycles with a pin low over a window
    task automatic lows(input int ch, input int n);
        k = 0;
        repeat (n) begin
            @(negedge clk);
            if (wave[ch] === 1'b0) k++;
        end
    endtask
    // Window edges fall mid-period, so allow a little slack
    task automatic near(input int e);
        check(16'(k > e - 16 && k < e + 16), 16'h1);
    endtask
    // Two reset cycles, then a quiet spell before the first strobe
    task automatic do_reset();
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        check(16'({data_oe, wave}), 16'h0000);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        $display("reset test done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        gate = 3'h0;
        do_reset();
        foreach (rows[i]) begin
            host.wr(ADDR_CTRL, {2'h2, FMT_LOW, rows[i][3:1], 1'b0});
            check(16'(wave[2]), 16'(rows[i][0]));
        end
        host.rd(ADDR_CTRL, b, oe);
        check(16'(oe), 16'h0);
        $display("mode table done");
        // Mid-run reset must drop the programmed counters again
        do_reset();
        // Mode 0: pause, terminal count, then a rewrite
        gate[0] = 1'b1;
        host.wr(ADDR_CTRL, 8'h10);
        host.wr(2'h0, 8'h05);
        ticks(2);
        gate[0] = 1'b0;
        ticks(10);
        check(16'(wave[0]), 16'h0);
        gate[0] = 1'b1;
        ticks(10);
        check(16'(wave[0]), 16'h1);
        host.wr(2'h0, 8'h08);
        ticks(5);
        check(16'(wave[0]), 16'h0);
        ticks(6);
        check(16'(wave[0]), 16'h1);
        $display("mode 0 test done");
        // Rate n=5: one low tick in five, none while gated off
        gate[1] = 1'b1;
        host.wr(ADDR_CTRL, 8'h74);
        host.wr16(2'h1, 16'h0005);
        ticks(2);
        lows(1, 500);
        near(100);
        gate[1] = 1'b0;
        ticks(1);
        lows(1, 100);
        check(16'(k), 16'h0);
        // Square n=5: high three ticks, low two
        host.wr(ADDR_CTRL, 8'h16);
        host.wr(2'h0, 8'h05);
        ticks(2);
        lows(0, 500);
        near(200);
        $display("periodic test done");
        // Latch holds until read whole, then reads follow the live count
        gate[1] = 1'b1;
        host.wr(ADDR_CTRL, 8'h74);
        host.wr16(2'h1, 16'h1000);
        ticks(3);
        host.wr(ADDR_CTRL, 8'h40);
        ticks(5);
        host.rd16(2'h1, v);
        host.rd16(2'h1, w);
        check(16'(v < 16'h1000 && v > 16'h0fe0), 16'h1);
        check(16'(w < v), 16'h1);
        // Decimal count, read directly once stopped
        gate[2] = 1'b1;
        host.wr(ADDR_CTRL, 8'hb1);
        host.wr16(2'h2, 16'h0010);
        ticks(4);
        gate[2] = 1'b0;
        ticks(1);
        host.rd16(2'h2, v);
        check(16'(v >= 16'h0001 && v <= 16'h0009), 16'h1);
        $display("read test done");
        // One-shot: write alone holds high, trigger runs on through an enable fall
        host.wr(ADDR_CTRL, 8'h92);
        host.wr(2'h2, 8'h04);
        ticks(2);
        check(16'(wave[2]), 16'h0001);
        gate[2] = 1'b1;
        ticks(1);
        gate[2] = 1'b0;
        lows(2, 100);
        near(35);
        check(16'(wave[2]), 16'h0001);
        // Hardware strobe: one clock low after three counts
        host.wr(ADDR_CTRL, 8'h9a);
        host.wr(2'h2, 8'h03);
        gate[2] = 1'b1;
        lows(2, 100);
        check(16'(k), 16'h000a);
        // Software strobe: a resumed count would strobe inside the first window
        host.wr(ADDR_CTRL, 8'h98);
        host.wr(2'h2, 8'h05);
        ticks(2);
        gate[2] = 1'b0;
        ticks(3);
        gate[2] = 1'b1;
        lows(2, 45);
        check(16'(k), 16'h0000);
        lows(2, 150);
        check(16'(k), 16'h000a);
        $display("strobe test done");
        report_and_stop();
    end
endmodule
